/* verilog/jtag_tap_regs.vh */
// Constants for the test access port: widths, instruction codes, capture values
`ifndef JTAG_TAP_REGS_VH
`define JTAG_TAP_REGS_VH
// Instruction chain width and fixed capture pattern
`define IR_W 4
`define IR_CAPTURE 4'h1
// Instruction codes
`define I_EXTEST 4'h0
`define I_INTEST 4'h1
`define I_SAMPLE 4'h2
`define I_USER 4'h3
`define I_ABORT 4'h8
`define I_DPACC 4'hA
`define I_APACC 4'hB
`define I_IDCODE 4'hE
`define I_BYPASS 4'hF
// Instruction loaded on entry to Test-Logic-Reset
`define IR_RESET `I_IDCODE
// Identification word, arbitrary neutral value
`define IDCODE_VAL 32'h1234_5671
`define ID_W 32
// Buffer depth and count values
`define BUF_CNT_W 2
`define BUF_FULL 2'h2
`define BUF_EMPTY 2'h0
`define BUF_ONE 2'h1
`endif

/* verilog/jtag_tap_controller.v */
// Test access port with instruction chain, data chains and core debug mux
// Notes on behaviour
// (RQ1) State moves only by test clock and mode
// (RQ2) Mode sampled on clock rise picks state
// (RQ3) Five high mode samples reach reset state
// (RQ4) Reset state restores all chains to defaults
// (RQ5) Power-on reset forces reset state directly
// (RQ6) Data input sampled on rise into chain
// (RQ7) Data output changes on falling clock edge
// (RQ8) Output undriven outside active shift states
// (RQ9) Unknown instruction codes act as bypass
// (RQ10) Pin-drive instructions touch no chain
// (RQ11) Held instruction selects the data chain
// (RQ12) State chooses instruction or data chain
// (RQ13) Capture loads, shift moves one bit
// (RQ14) Update copies chain into parallel register
// (RQ15) Stopped test clock keeps everything unchanged; the user buffer still drains when out_ready is high
// (RQ16) Host changes mode on falling edge
// (RQ17) Host changes data input on falling edge
// (RQ18) Host resets with five high mode cycles
// (RQ19) Instruction chain is four bits wide
// (RQ20) Output muxed with core debug port
// (RQ21) Sixteen-state standard graph with pause states
`timescale 1ns/100ps
`include "jtag_tap_regs.vh"
module jtag_tap_controller #(
  parameter BSR_W = 8,
  parameter USR_W = 8
) (
  input wire core_clk,
  input wire rst_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  output wire tdo_o,
  output wire tdo_oe,
  input wire core_tdo,
  output wire core_sel,
  input wire [BSR_W-1:0] bsr_capture,
  output wire [BSR_W-1:0] bsr_update,
  output wire extest_active,
  output wire intest_active,
  output wire [USR_W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  // ****************************************
  // State codes
  // ****************************************
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDS = 16'h0004;
  localparam [15:0] S_CD = 16'h0008;
  localparam [15:0] S_SD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PD = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UD = 16'h0100;
  localparam [15:0] S_SIS = 16'h0200;
  localparam [15:0] S_CI = 16'h0400;
  localparam [15:0] S_SI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PI = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UI = 16'h8000;
  // Maps unimplemented codes onto bypass
  function [`IR_W-1:0] decode_instr;
    input [`IR_W-1:0] code;
    begin
      case (code)
        `I_EXTEST, `I_INTEST, `I_SAMPLE, `I_USER, `I_ABORT,
        `I_DPACC, `I_APACC, `I_IDCODE: decode_instr = code;
        default: decode_instr = `I_BYPASS; // RQ9
      endcase
    end
  endfunction
  // True for instructions served by the core debug port
  function is_core;
    input [`IR_W-1:0] code;
    begin
      is_core = (code == `I_ABORT) || (code == `I_DPACC) || (code == `I_APACC);
    end
  endfunction

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  reg tck_m_q, tck_s_q, tck_p_q;
  reg tms_m_q, tms_s_q;
  reg tdi_m_q, tdi_s_q;
  reg ctdo_m_q, ctdo_s_q;
  wire tck_rise;
  wire tck_fall;
  // Two flops on every pin before use
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tck_m_q <= 1'b1;
      tck_s_q <= 1'b1;
      tck_p_q <= 1'b1;
      tms_m_q <= 1'b1;
      tms_s_q <= 1'b1;
      tdi_m_q <= 1'b1;
      tdi_s_q <= 1'b1;
      ctdo_m_q <= 1'b0;
      ctdo_s_q <= 1'b0;
    end
    else
    begin
      tck_m_q <= tck;
      tck_s_q <= tck_m_q;
      tck_p_q <= tck_s_q;
      tms_m_q <= tms;
      tms_s_q <= tms_m_q;
      tdi_m_q <= tdi;
      tdi_s_q <= tdi_m_q;
      ctdo_m_q <= core_tdo;
      ctdo_s_q <= ctdo_m_q;
    end
  end

  // Edges of the test clock; none while it stands still
  assign tck_rise = tck_s_q & ~tck_p_q; // RQ15
  assign tck_fall = ~tck_s_q & tck_p_q; // RQ15

  // ****************************************
  // TAP state machine
  // ****************************************
  reg [15:0] state_q;
  reg [15:0] state_d;
  // Next state from present state and sampled mode
  always @*
  begin
    state_d = S_TLR;
    case (state_q) // RQ21
      S_TLR: state_d = tms_s_q ? S_TLR : S_RTI; // RQ3
      S_RTI: state_d = tms_s_q ? S_SDS : S_RTI;
      S_SDS: state_d = tms_s_q ? S_SIS : S_CD;
      S_CD: state_d = tms_s_q ? S_E1D : S_SD;
      S_SD: state_d = tms_s_q ? S_E1D : S_SD;
      S_E1D: state_d = tms_s_q ? S_UD : S_PD;
      S_PD: state_d = tms_s_q ? S_E2D : S_PD;
      S_E2D: state_d = tms_s_q ? S_UD : S_SD;
      S_UD: state_d = tms_s_q ? S_SDS : S_RTI;
      S_SIS: state_d = tms_s_q ? S_TLR : S_CI; // RQ3
      S_CI: state_d = tms_s_q ? S_E1I : S_SI;
      S_SI: state_d = tms_s_q ? S_E1I : S_SI;
      S_E1I: state_d = tms_s_q ? S_UI : S_PI;
      S_PI: state_d = tms_s_q ? S_E2I : S_PI;
      S_E2I: state_d = tms_s_q ? S_UI : S_SI;
      S_UI: state_d = tms_s_q ? S_SDS : S_RTI;
      default: state_d = S_TLR;
    endcase
  end
  // State advances only on a test clock rise
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= S_TLR; // RQ5
    else if (tck_rise) // RQ1 RQ2
      state_q <= state_d;
  end

  // ****************************************
  // Instruction chain
  // ****************************************
  reg [`IR_W-1:0] ir_shift_q; // RQ19
  reg [`IR_W-1:0] ir_q;
  wire [`IR_W-1:0] instr;
  wire in_tlr;
  wire pin_instr;
  assign in_tlr = (state_q == S_TLR);
  assign instr = decode_instr(ir_q);
  assign pin_instr = (instr == `I_EXTEST) || (instr == `I_INTEST);
  // Capture, shift and update of the instruction chain
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir_shift_q <= `IR_CAPTURE;
      ir_q <= `IR_RESET;
    end
    else if (in_tlr)
    begin
      ir_shift_q <= `IR_CAPTURE; // RQ4
      ir_q <= `IR_RESET; // RQ4
    end
    else if (tck_rise)
    begin
      case (state_q) // RQ12
        S_CI: ir_shift_q <= `IR_CAPTURE; // RQ13
        S_SI: ir_shift_q <= {tdi_s_q, ir_shift_q[`IR_W-1:1]}; // RQ6 RQ13
        S_UI: ir_q <= ir_shift_q; // RQ14
        default: ir_q <= ir_q;
      endcase
    end
  end

  // ****************************************
  // Data chains
  // ****************************************
  reg byp_q;
  reg [`ID_W-1:0] id_shift_q;
  reg [BSR_W-1:0] bsr_shift_q;
  reg [BSR_W-1:0] bsr_upd_q;
  reg [USR_W-1:0] usr_shift_q;
  reg [USR_W-1:0] buf_mem [0:1];
  reg buf_wr_q;
  reg buf_rd_q;
  reg [`BUF_CNT_W-1:0] buf_cnt_q;
  wire dr_cap;
  wire dr_sh;
  wire dr_upd;
  wire buf_in_ready;
  wire buf_push;
  wire buf_pop;
  // Data chain actions, suppressed under pin-drive instructions
  assign dr_cap = tck_rise && (state_q == S_CD) && !pin_instr; // RQ10
  assign dr_sh = tck_rise && (state_q == S_SD) && !pin_instr; // RQ10
  assign dr_upd = tck_rise && (state_q == S_UD) && !pin_instr; // RQ10
  assign buf_in_ready = (buf_cnt_q != `BUF_FULL);
  assign buf_push = dr_upd && (instr == `I_USER) && buf_in_ready;
  assign buf_pop = (buf_cnt_q != `BUF_EMPTY) && out_ready;
  // Chain selected by the held instruction
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byp_q <= 1'b0;
      id_shift_q <= `IDCODE_VAL;
      bsr_shift_q <= {BSR_W{1'b0}};
      bsr_upd_q <= {BSR_W{1'b0}};
      usr_shift_q <= {USR_W{1'b0}};
    end
    else if (in_tlr)
    begin
      byp_q <= 1'b0; // RQ4
      id_shift_q <= `IDCODE_VAL; // RQ4
      bsr_shift_q <= {BSR_W{1'b0}}; // RQ4
      bsr_upd_q <= {BSR_W{1'b0}}; // RQ4
      usr_shift_q <= {USR_W{1'b0}}; // RQ4
    end
    else if (dr_cap)
    begin
      case (instr) // RQ11 RQ13
        `I_IDCODE: id_shift_q <= `IDCODE_VAL;
        `I_SAMPLE: bsr_shift_q <= bsr_capture;
        `I_USER: usr_shift_q <= {{(USR_W-1){1'b0}}, buf_in_ready};
        `I_BYPASS: byp_q <= 1'b0;
        default: byp_q <= byp_q;
      endcase
    end
    else if (dr_sh)
    begin
      case (instr) // RQ6 RQ11 RQ13
        `I_IDCODE: id_shift_q <= {tdi_s_q, id_shift_q[`ID_W-1:1]};
        `I_SAMPLE: bsr_shift_q <= {tdi_s_q, bsr_shift_q[BSR_W-1:1]};
        `I_USER: usr_shift_q <= {tdi_s_q, usr_shift_q[USR_W-1:1]};
        `I_BYPASS: byp_q <= tdi_s_q;
        default: byp_q <= byp_q;
      endcase
    end
    else if (dr_upd && (instr == `I_SAMPLE))
      bsr_upd_q <= bsr_shift_q; // RQ14
  end

  // ****************************************
  // Two-entry buffer for user words
  // ****************************************
  // Update pushes the word; capture reports space so the host waits
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_wr_q <= 1'b0;
      buf_rd_q <= 1'b0;
      buf_cnt_q <= `BUF_EMPTY;
      buf_mem[0] <= {USR_W{1'b0}};
      buf_mem[1] <= {USR_W{1'b0}};
    end
    else if (in_tlr)
    begin
      buf_wr_q <= 1'b0; // RQ4
      buf_rd_q <= 1'b0;
      buf_cnt_q <= `BUF_EMPTY;
    end
    else
    begin
      if (buf_push)
      begin
        buf_mem[buf_wr_q] <= usr_shift_q; // RQ14
        buf_wr_q <= ~buf_wr_q;
      end
      if (buf_pop)
        buf_rd_q <= ~buf_rd_q;
      if (buf_push && !buf_pop)
        buf_cnt_q <= buf_cnt_q + `BUF_ONE;
      else if (buf_pop && !buf_push)
        buf_cnt_q <= buf_cnt_q - `BUF_ONE;
    end
  end

  assign out_data = buf_mem[buf_rd_q];
  assign out_valid = (buf_cnt_q != `BUF_EMPTY);

  // ****************************************
  // Serial output
  // ****************************************
  reg tdo_q;
  reg tdo_oe_q;
  reg tdo_src;
  reg tdo_drv;
  // Source and drive for the present state and instruction
  always @*
  begin
    tdo_src = 1'b0;
    tdo_drv = 1'b0;
    if (state_q == S_SI) // RQ12
    begin
      tdo_src = ir_shift_q[0];
      tdo_drv = 1'b1;
    end
    else if (state_q == S_SD)
    begin
      tdo_drv = !pin_instr; // RQ8 RQ10
      if (is_core(instr))
        tdo_src = ctdo_s_q; // RQ20
      else if (instr == `I_IDCODE)
        tdo_src = id_shift_q[0];
      else if (instr == `I_SAMPLE)
        tdo_src = bsr_shift_q[0];
      else if (instr == `I_USER)
        tdo_src = usr_shift_q[0];
      else
        tdo_src = byp_q; // RQ9
    end
  end
  // Output and its enable change on the falling test clock edge
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else if (in_tlr)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0; // RQ8
    end
    else if (tck_fall) // RQ7
    begin
      tdo_q <= tdo_src;
      tdo_oe_q <= tdo_drv; // RQ8
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe = tdo_oe_q;
  assign core_sel = is_core(instr); // RQ20
  assign bsr_update = bsr_upd_q;
  assign extest_active = (instr == `I_EXTEST); // RQ10
  assign intest_active = (instr == `I_INTEST); // RQ10

endmodule

/* sim/jtag_tap_assertions.sv */
// Port timing checker for the test access port
`timescale 1ns/100ps
module jtag_tap_assertions #(parameter BSR_W = 8, parameter USR_W = 8) (
  input wire core_clk,
  input wire rst_n,
  input wire tck,
  input wire tdo_o,
  input wire tdo_oe,
  input wire core_sel,
  input wire extest_active,
  input wire intest_active,
  input wire [BSR_W-1:0] bsr_update,
  input wire [USR_W-1:0] out_data,
  input wire out_valid,
  input wire out_ready
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Serial output moves only in the low phase
  tdo_fall_a: assert property ($changed({tdo_o, tdo_oe}) |-> !tck)
    else $error("tdo moved in high phase");
  rst_quiet_a: assert property (disable iff (1'b0)
    !rst_n ##1 !rst_n |-> !tdo_oe && !out_valid)
    else $error("outputs live in reset");
  mode_excl_a: assert property (core_sel |-> !extest_active && !intest_active)
    else $error("core and pin modes overlap");
  pin_hold_a: assert property (extest_active && $past(extest_active) |-> $stable(bsr_update))
    else $error("update moved in pin mode");
  upd_high_a: assert property ($changed(bsr_update) |-> tck)
    else $error("update moved in low phase");
  push_high_a: assert property ($rose(out_valid) |-> tck)
    else $error("push in low phase");
  idle_keep_a: assert property ($stable(tck) [*8] |-> $stable({tdo_o, tdo_oe, bsr_update}))
    else $error("change with clock stopped");
  stall_hold_a: assert property (!tck && out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("word lost in stall");
endmodule

/* sim/jtag_host_model.sv */
// Test host model driving the serial test pins
`timescale 1ns/100ps
module jtag_host_model (
  input wire core_clk,
  input wire tdo_line,
  output reg tck,
  output reg tms,
  output reg tdi
);
  // ****
  // Pin sequencing
  // ****
  initial
  begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One clock period, pins moved at the fall
  task step(input reg m, input reg b, output reg q);
    begin
      tck <= 1'b0;
      tms <= m;
      tdi <= b;
      repeat (10) @(posedge core_clk);
      q = tdo_line;
      tck <= 1'b1;
      repeat (10) @(posedge core_clk);
    end
  endtask
  // Five high mode periods, then idle
  task reset5;
    reg q;
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1)
        step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
    end
  endtask
  // Whole scan from idle, LSB first
  task scan(input reg ir, input reg [31:0] din, input integer n, output reg [31:0] dout);
    reg q;
    integer i;
    begin
      dout = 32'h0000_0000;
      step(1'b1, 1'b1, q);
      if (ir)
        step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (i = 0; i < n; i = i + 1)
      begin
        step(i == n - 1, din[i], q);
        dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
    end
  endtask
endmodule

/* sim/jtag_tap_controller_tb_top.sv */
// Self-checking bench for the test access port
`timescale 1ns/100ps
`include "jtag_tap_regs.vh"
module jtag_tap_controller_tb_top;
  // ****
  // Bench
  // ****
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg core_tdo = 1'b0;
  reg out_ready = 1'b0;
  reg stall = 1'b1;
  reg q = 1'b0;
  reg [3:0] c;
  reg [7:0] bsr_capture = 8'h00;
  wire tck, tms, tdi, tdo_o, tdo_oe, core_sel, extest_active, intest_active, out_valid;
  wire [7:0] bsr_update, out_data;
  reg [31:0] seen, got, d, e;
  reg [31:0] exp_q[$];
  reg [31:0] usr_q[$];
  integer err_total = 0, n_compared = 0, cyc = 0, i;
  event scan_done;
  always #2 core_clk = ~core_clk;
  jtag_tap_controller #(.BSR_W(8), .USR_W(8)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_tdo(core_tdo),
    .core_sel(core_sel), .bsr_capture(bsr_capture), .bsr_update(bsr_update),
    .extest_active(extest_active), .intest_active(intest_active), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready));
  // Released output line is pulled up
  jtag_host_model host_u (.core_clk(core_clk), .tdo_line(tdo_oe ? tdo_o : 1'b1),
    .tck(tck), .tms(tms), .tdi(tdi));
  task check(input [31:0] s, input [31:0] x);
    begin
      n_compared = n_compared + 1;
      if (s !== x)
      begin
        err_total = err_total + 1;
        $display("mismatch at %0t seen %h expected %h", $time, s, x);
      end
    end
  endtask
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task scan_chk(input reg ir, input [31:0] din, input integer n, input [31:0] x, input [31:0] m);
    begin
      exp_q.push_back(x & m);
      host_u.scan(ir, din, n, got);
      seen = got & m;
      -> scan_done;
    end
  endtask
  // Expected data scan output per instruction
  function [31:0] dr_exp(input [3:0] k, input [31:0] v);
    case (k)
      `I_EXTEST, `I_INTEST: dr_exp = 32'h0000_00ff;
      `I_SAMPLE: dr_exp = {24'h0000_00, bsr_capture};
      `I_ABORT, `I_DPACC, `I_APACC: dr_exp = {32{core_tdo}};
      `I_IDCODE: dr_exp = `IDCODE_VAL;
      default: dr_exp = {v[30:0], 1'b0};
    endcase
  endfunction
  // Scan results against the oldest note
  always @(scan_done)
    check(seen, exp_q.pop_front());
  // Drain side, popped words and timeout
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    out_ready <= stall ? 1'b0 : $urandom_range(0, 1);
    if (out_valid === 1'b1 && out_ready === 1'b1)
      check({24'h0000_00, out_data}, usr_q.size() ? usr_q.pop_front() : 32'hxxxx_xxxx);
    if (cyc == 40000)
    begin
      err_total = err_total + 1;
      conclude;
    end
  end
  // Main sequence
  initial
  begin
    d = $urandom(96964);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check({21'h0, bsr_update, core_sel, extest_active, intest_active}, 32'h0);
    host_u.reset5();
    scan_chk(0, 0, 32, `IDCODE_VAL, 32'hffff_ffff);
    for (i = 0; i < 32; i = i + 1)
    begin
      c = i[3:0];
      d = $urandom;
      bsr_capture <= d[15:8];
      core_tdo <= d[16];
      e = bsr_update;
      scan_chk(1, c, 4, `IR_CAPTURE, 32'h0000_000f);
      check({extest_active, intest_active, core_sel},
        {c == `I_EXTEST, c == `I_INTEST, c == `I_ABORT || c == `I_DPACC || c == `I_APACC});
      if (c != `I_USER)
        scan_chk(0, d, 8, dr_exp(c, d), 32'h0000_00ff);
      check(bsr_update, c == `I_SAMPLE ? d[7:0] : e[7:0]);
    end
    scan_chk(1, `I_USER, 4, `IR_CAPTURE, 32'h0000_000f);
    for (i = 0; i < 3; i = i + 1)
    begin
      d = $urandom;
      if (i < 2)
        usr_q.push_back(d[7:0]);
      scan_chk(0, d, 8, i < 2, 32'h0000_0001);
    end
    stall <= 1'b0;
    for (i = 0; i < 300 && out_valid !== 1'b0; i = i + 1)
      @(posedge core_clk);
    check(usr_q.size(), 0);
    stall <= 1'b1;
    d = $urandom;
    scan_chk(0, d, 8, 1, 32'h0000_0001);
    check(out_valid, 1'b1);
    host_u.step(1'b1, 1'b1, q);
    host_u.step(1'b0, 1'b1, q);
    host_u.step(1'b0, 1'b1, q);
    host_u.reset5();
    usr_q.delete();
    check(out_valid, 1'b0);
    scan_chk(0, 0, 32, `IDCODE_VAL, 32'hffff_ffff);
    @(posedge core_clk);
    conclude;
  end
endmodule
bind jtag_tap_controller jtag_tap_assertions #(.BSR_W(BSR_W), .USR_W(USR_W)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
  .core_sel(core_sel), .extest_active(extest_active), .intest_active(intest_active),
  .bsr_update(bsr_update), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
